// [inc/fms_pkg.sv]
// constants and types for the multiplexer scan sequencer
// assumes a 100 MHz clock and no register bus
package fms_pkg;
  localparam int CHAN_W = 5;
  localparam int BANK_SIZE = 8;
  localparam int LIST_DEPTH = 64;
  localparam int PTR_W = 6;
  localparam int COUNT_W = 16;
  localparam logic [CHAN_W-1:0] PARTNER_OFFSET = 5'h08;
  localparam logic [PTR_W-1:0] PTR_RESET = 6'h00;
  localparam logic [COUNT_W-1:0] PASS_RESET = 16'h0000;
  localparam int CLK_HZ = 100000000;
  localparam int MAX_STEP_PER_S = 100000;
  localparam int STEP_CYCLES = CLK_HZ / MAX_STEP_PER_S;
  localparam logic [15:0] STEP_CYCLES_W = 16'(STEP_CYCLES);
  localparam logic [1:0] MEAS_VOLT = 2'h0;
  localparam logic [1:0] MEAS_TWO_WIRE = 2'h1;
  localparam logic [1:0] MEAS_FOUR_WIRE = 2'h2;
  typedef enum logic [2:0] {
    TRIG_HOST_CMD, TRIG_OUTSIDE_PORT, TRIG_HOLD,
    TRIG_HANDSHAKE, TRIG_FREE_RUN
  } fms_trig_type;
  typedef enum logic [1:0] {ST_IDLE, ST_OPEN, ST_CLOSED} fms_state_type;
endpackage

// [logic/fms_sequencer.sv]
// scan sequencer: walks a channel list and drives channel and tree switches
// assumes outside port and meter triggers arrive as pins and list writes come from logic on mclk
`timescale 1ns/1ps
`default_nettype none
module fms_sequencer #(
  parameter int NUM_CHAN = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // configuration
  input wire logic [1:0] meas_mode,
  input wire logic analog_backplane_route,
  input wire fms_pkg::fms_trig_type trig_source,
  input wire logic relay_modules_mixed,
  input wire logic endless_scan_enable,
  input wire logic [fms_pkg::COUNT_W-1:0] repeat_count,
  input wire logic [fms_pkg::PTR_W-1:0] list_length,
  // channel list load, same clock
  input wire logic list_wr,
  input wire logic [fms_pkg::PTR_W-1:0] list_wr_addr,
  input wire logic [fms_pkg::CHAN_W-1:0] list_wr_chan,
  // host commands, same clock
  input wire logic initiate,
  input wire logic host_trigger,
  input wire logic abort,
  // pins from the meter and outside port
  input wire logic outside_port_trigger,
  input wire logic meter_complete,
  // switch drive
  output logic [NUM_CHAN-1:0] chan_close,
  output logic tree_a_close,
  output logic tree_b_close,
  output logic backplane_close,
  // status
  output logic scanning,
  output logic memory_list_mode,
  output logic channel_closed,
  output logic scan_done,
  output logic [fms_pkg::PTR_W-1:0] list_ptr
);
  import fms_pkg::*;

  // every module keeps the full list; unused channels simply never close
  logic [CHAN_W-1:0] list_mem [LIST_DEPTH];
  fms_state_type state_q, state_d;
  logic [PTR_W-1:0] ptr_q;
  logic [COUNT_W-1:0] pass_q;
  logic [15:0] pace_q;
  logic [NUM_CHAN-1:0] close_q;
  logic done_q;
  logic ext_s1_q, ext_s2_q, ext_s3_q;
  logic vmc_s1_q, vmc_s2_q, vmc_s3_q;

  // memory-held list only for handshake or free-run, never with relays
  wire mem_mode = !relay_modules_mixed &&
    (trig_source == TRIG_HANDSHAKE || trig_source == TRIG_FREE_RUN);
  wire ext_edge = ext_s2_q && !ext_s3_q;
  wire vmc_edge = vmc_s2_q && !vmc_s3_q;
  wire pace_ok = (pace_q == 16'h0000);
  wire host_step = (trig_source == TRIG_HOST_CMD && host_trigger) ||
    (trig_source == TRIG_OUTSIDE_PORT && ext_edge);
  // hold source only steps on an immediate host trigger
  wire hold_step = trig_source == TRIG_HOLD && host_trigger;
  wire mem_step = pace_ok && ((trig_source == TRIG_FREE_RUN) ||
    (trig_source == TRIG_HANDSHAKE && vmc_edge));
  wire step = (state_q == ST_CLOSED) &&
    (mem_mode ? mem_step : (host_step || hold_step));
  wire last_entry = (ptr_q == list_length - 6'h01);
  wire last_pass = (pass_q + 16'h0001 >= repeat_count);
  // count ignored for memory lists; endless overrides both
  wire more_passes = endless_scan_enable ||
    (!mem_mode && !last_pass && repeat_count != PASS_RESET);
  wire finish = step && last_entry && !more_passes;
  wire [CHAN_W-1:0] cur_chan = list_mem[ptr_q];
  wire [CHAN_W-1:0] partner_chan = cur_chan + PARTNER_OFFSET;
  wire four_wire = (meas_mode == MEAS_FOUR_WIRE);
  wire two_wire = (meas_mode == MEAS_TWO_WIRE);
  wire start_scan = (state_q == ST_IDLE) && initiate;
  wire wrap = step && last_entry;
  // partner only exists for bank 0 channels
  wire pair_on = four_wire && (cur_chan < CHAN_W'(BANK_SIZE));
  logic [NUM_CHAN-1:0] close_d;

  // open before close: one cycle in ST_OPEN with every channel open
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (initiate && list_length != PTR_RESET) begin
          state_d = ST_OPEN;
        end
      end
      ST_OPEN: begin
        state_d = ST_CLOSED;
      end
      ST_CLOSED: begin
        if (finish) begin
          state_d = ST_IDLE;
        end else if (step) begin
          state_d = ST_OPEN;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (abort) begin
      state_d = ST_IDLE;
    end
  end

  // list memory has no reset; load it before initiate
  always_ff @(posedge mclk) begin
    if (list_wr) begin
      list_mem[list_wr_addr] <= list_wr_chan;
    end
  end

  // two flops per pin before the edge detector reads them
  always_ff @(posedge mclk) begin
    ext_s1_q <= outside_port_trigger;
    ext_s2_q <= ext_s1_q;
    ext_s3_q <= ext_s2_q;
  end

  always_ff @(posedge mclk) begin
    vmc_s1_q <= meter_complete;
    vmc_s2_q <= vmc_s1_q;
    vmc_s3_q <= vmc_s2_q;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // list pointer; wraps to the first entry after the last
  always_ff @(posedge mclk) begin
    if (sys_rst || start_scan) begin
      ptr_q <= PTR_RESET;
    end else if (wrap) begin
      ptr_q <= PTR_RESET;
    end else if (step) begin
      ptr_q <= ptr_q + 6'h01;
    end
  end

  // passes done; memory lists never look at it
  always_ff @(posedge mclk) begin
    if (sys_rst || start_scan) begin
      pass_q <= PASS_RESET;
    end else if (wrap) begin
      pass_q <= pass_q + 16'h0001;
    end
  end

  // paces the free-running list to the rated switching speed
  always_ff @(posedge mclk) begin
    if (sys_rst || step) begin
      pace_q <= STEP_CYCLES_W - 16'h0001;
    end else if (!pace_ok) begin
      pace_q <= pace_q - 16'h0001;
    end
  end

  // one select per switch: the listed channel or its bank 1 partner
  for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
    wire is_main = (cur_chan == CHAN_W'(ch));
    wire is_pair = pair_on && (partner_chan == CHAN_W'(ch));
    assign close_d[ch] = (state_d == ST_CLOSED) && (is_main || is_pair);
  end

  // registered so the switch drive never glitches between entries
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      close_q <= '0;
    end else begin
      close_q <= close_d;
    end
  end

  // sticky until the next initiate so the host can poll it
  always_ff @(posedge mclk) begin
    if (sys_rst || start_scan) begin
      done_q <= 1'b0;
    end else if (finish) begin
      done_q <= 1'b1;
    end
  end

  assign chan_close = close_q;
  // tree a carries the signal; tree b brings the ohms source in
  assign tree_a_close = |close_q;
  assign tree_b_close = (|close_q) && (two_wire || four_wire);
  assign backplane_close = (|close_q) && analog_backplane_route;
  assign scanning = (state_q != ST_IDLE);
  assign memory_list_mode = mem_mode;
  assign channel_closed = (state_q == ST_CLOSED);
  assign scan_done = done_q;
  assign list_ptr = ptr_q;
endmodule
`default_nettype wire

// [testbench/fms_meter_model.sv]
// meter model: answers a channel held closed past 1000 cycles (1040 when slow) with a complete pulse
// assumes channel_closed comes from the sequencer on mclk
`timescale 1ns/1ps
`default_nettype none
module fms_meter_model (
  // clock and sequencer status
  input wire logic mclk,
  input wire logic channel_closed,
  input wire logic slow,
  // back to the sequencer
  output var logic meter_complete
);
  int n = 0;
  initial meter_complete = 1'b0;
  // answers wait out the sequencer's step pacing; slow adds more delay
  always @(posedge mclk) begin
    n = channel_closed ? n + 1 : 0;
    meter_complete <= (n > (slow ? 1040 : 1000)) && (n < (slow ? 1045 : 1005));
  end
endmodule
`default_nettype wire

// [testbench/fms_sequencer_sva.sv]
// assertions on the scan sequencer ports
// assumes one clock domain with synchronous reset
`timescale 1ns/1ps
`default_nettype none
module fms_sequencer_sva #(
  parameter int NUM_CHAN = 16
) (
  // clock and configuration
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [1:0] meas_mode,
  input wire fms_pkg::fms_trig_type trig_source,
  input wire logic relay_modules_mixed,
  input wire logic [fms_pkg::PTR_W-1:0] list_length,
  input wire logic initiate,
  input wire logic host_trigger,
  // outputs watched
  input wire logic [NUM_CHAN-1:0] chan_close,
  input wire logic tree_b_close,
  input wire logic scanning,
  input wire logic memory_list_mode,
  input wire logic channel_closed,
  input wire logic [fms_pkg::PTR_W-1:0] list_ptr
);
  import fms_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire hstep = channel_closed && host_trigger && trig_source == TRIG_HOST_CMD;
  wire last = list_ptr + 6'h01 == list_length;
  wire memsrc = trig_source == TRIG_HANDSHAKE || trig_source == TRIG_FREE_RUN;
  wire fr_closed = channel_closed && memory_list_mode && trig_source == TRIG_FREE_RUN;
  // cycles the current channel has stood closed
  logic [15:0] held_q;
  always_ff @(posedge mclk) begin
    if (sys_rst || !channel_closed) begin
      held_q <= 16'h0000;
    end else begin
      held_q <= held_q + 16'h0001;
    end
  end
  sequence s_reopen;
    chan_close == '0 ##1 channel_closed;
  endsequence
  sequence s_start;
    scanning ##1 channel_closed;
  endsequence
  a_step_opens_first: assert property (hstep && !last |=> s_reopen)
    else $error("host step did not open then close");
  a_ptr_one_step: assert property (hstep && !last |=> ##1 list_ptr == $past(list_ptr, 2) + 6'h01)
    else $error("pointer did not advance by one");
  a_ptr_wraps: assert property (hstep && last |=> ##1 list_ptr == PTR_RESET)
    else $error("pointer did not wrap");
  a_pair_close: assert property (meas_mode == MEAS_FOUR_WIRE && chan_close[7:0] != 8'h00 |-> chan_close[15:8] == chan_close[7:0])
    else $error("partner channel not closed");
  a_tree_two_wire: assert property (meas_mode == MEAS_TWO_WIRE && chan_close != '0 |-> tree_b_close)
    else $error("tree switch missing in two-wire");
  a_start_close: assert property (initiate && !scanning && list_length != 6'h00 |=> s_start)
    else $error("first channel late");
  a_mem_mode_src: assert property (memory_list_mode == (memsrc && !relay_modules_mixed))
    else $error("memory list mode wrong");
  a_mem_self_step: assert property (fr_closed |-> held_q < STEP_CYCLES_W)
    else $error("memory list stalled");
endmodule
bind fms_sequencer fms_sequencer_sva #(.NUM_CHAN(NUM_CHAN)) chk_u (.*);
`default_nettype wire

// [testbench/tb_top.sv]
// bench for the scan sequencer with a meter model
// assumes package, meter model and checker compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; $display("BAD %0t %h %h", $time, a, b); end end
module tb_top;
  import fms_pkg::*;
  logic mclk = 0, sys_rst = 1, slow = 0, mix = 0, endl = 0, ini = 0, ht = 0, ot = 0, wr = 0, mc;
  logic abt = 0, rt = 1;
  logic tra, trb, bp, scn, mem, cl, done;
  logic [1:0] mode = MEAS_TWO_WIRE;
  fms_trig_type src = TRIG_HOST_CMD;
  logic [15:0] rep = 16'h0002, cc;
  logic [5:0] wa = 6'h00, ptr;
  logic [4:0] wc = 5'h00, lst [3];
  int fails = 0, n_tests = 0;
  fms_sequencer dut_u (.mclk(mclk), .sys_rst(sys_rst), .meas_mode(mode),
    .analog_backplane_route(rt), .trig_source(src), .relay_modules_mixed(mix),
    .endless_scan_enable(endl), .repeat_count(rep), .list_length(6'h03), .list_wr(wr),
    .list_wr_addr(wa), .list_wr_chan(wc), .initiate(ini), .host_trigger(ht), .abort(abt),
    .outside_port_trigger(ot), .meter_complete(mc), .chan_close(cc), .tree_a_close(tra),
    .tree_b_close(trb), .backplane_close(bp), .scanning(scn), .memory_list_mode(mem),
    .channel_closed(cl), .scan_done(done), .list_ptr(ptr));
  fms_meter_model meter_u (.mclk(mclk), .channel_closed(cl), .slow(slow), .meter_complete(mc));
  task automatic complete_run();
    $display("fails=%0d n_tests=%0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic waitc(logic v);
    int k;
    for (k = 0; k < 3000 && cl !== v; k++) tick(1);
    if (k == 3000) begin
      fails++;
      complete_run();
    end
  endtask
  function automatic logic [15:0] ex(logic [4:0] c);
    ex = 16'h0001 << c;
    if (mode == MEAS_FOUR_WIRE && c < 5'h08) ex |= 16'h0001 << (c + 5'h08);
  endfunction
  // walks passes*3 closes; host sources get one trigger per close
  task automatic run(int passes, bit fin);
    ini = 1;
    tick(1);
    ini = 0;
    for (int i = 0; i < passes * 3; i++) begin
      waitc(1);
      `CHK(cc, ex(lst[i % 3]))
      `CHK({tra, trb, bp}, {1'b1, mode != MEAS_VOLT, rt})
      `CHK(ptr, 6'(i % 3))
      ht = !mem && src != TRIG_OUTSIDE_PORT;
      ot = !mem && !ht;
      tick(1);
      ht = 0;
      waitc(0);
      ot = 0;
    end
    tick(2);
    if (fin) `CHK({done, cc}, 17'h10000)
    else `CHK(scn, 1'b1)
  endtask
  initial begin
    forever #5 mclk = ~mclk;
  end
  initial begin
    void'($urandom(28));
    tick(5);
    sys_rst = 0;
    for (int k = 0; k < 3; k++) begin
      lst[k] = 5'(k * 6) + 5'($urandom % 2);
      wa = 6'(k);
      wc = lst[k];
      wr = 1;
      tick(1);
    end
    wr = 0;
    for (int s = 0; s < 5; s++) begin
      src = fms_trig_type'(s);
      mode = s == 1 ? MEAS_FOUR_WIRE : (s == 0 ? MEAS_VOLT : MEAS_TWO_WIRE);
      rt = s != 2;
      slow = s == 3;
      run(s < 3 ? 2 : 1, 1);
    end
    mix = 1;
    src = TRIG_HANDSHAKE;
    tick(1);
    `CHK(mem, 1'b0)
    mix = 0;
    src = TRIG_HOST_CMD;
    ini = 1;
    tick(1);
    ini = 0;
    waitc(1);
    abt = 1;
    tick(1);
    abt = 0;
    `CHK({scn, done, cc}, 18'h00000)
    endl = 1;
    src = TRIG_FREE_RUN;
    run(2, 0);
    endl = 0;
    for (int k = 0; k < 6000 && scn; k++) tick(1);
    `CHK({scn, done}, 2'b01)
    complete_run();
  end
endmodule
`default_nettype wire
